// ==== rtl/psram_core.v ====
// pipelined burst sram core: clock hold, chip selects, write pairing
//
// Contract
// [RULE1] edge_hold_n high at an edge: that edge is ignored completely.
// [RULE2] on a held edge every internal register keeps its value; here synchronisers, the buffer, rd_valid and pipe_stall still update.
// [RULE3] master drives valid lane strobes on every write and burst-write cycle.
// [RULE4] write starts when read_not_write is low at a new load.
// [RULE5] strobes come with the command; data follows two enabled edges later.
// [RULE6] select_high active high, the other two low; all three needed.
// [RULE7] advance_or_load sampled low ends any burst and loads new address.
// [RULE8] read_not_write is ignored while advancing; burst keeps load direction.
// [RULE9] two lowest address bits step linear or interleaved per burst_order_sel_n.
// [RULE10] deselected load starts nothing; transfers already in flight complete.
`timescale 1ns/1ps
`include "psram_defs.vh"

module psram_core #(
  parameter AW = `PSRAM_ADDR_W,
  parameter LANES = `PSRAM_LANES,
  parameter LW = `PSRAM_LANE_W
) (
  // clock and reset
  input wire clk,
  input wire nrst,
  // control pins
  input wire edge_hold_n,
  input wire advance_or_load,
  input wire read_not_write,
  input wire select_low_a,
  input wire select_low_b,
  input wire select_high,
  input wire burst_order_sel_n,
  input wire [AW-1:0] addr,
  input wire [LANES-1:0] lane_write_strobes_n,
  // write data pins
  input wire [LANES*LW-1:0] wr_data,
  // paired write stream towards the array
  output reg wr_valid,
  output reg [AW-1:0] wr_addr,
  output reg [LANES-1:0] wr_lanes,
  output reg [LANES*LW-1:0] wr_word,
  input wire wr_ready,
  // read request stream towards the array
  output reg rd_valid,
  output reg [AW-1:0] rd_addr,
  // status
  output reg pipe_stall
);

  // ---------------------------------------------------------------
  // reset release and pin synchronisers
  // ---------------------------------------------------------------
  reg rst_a_r, rst_b_r;
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rst_a_r <= 1'b0;
      rst_b_r <= 1'b0;
    end else begin
      rst_a_r <= 1'b1;
      rst_b_r <= rst_a_r;
    end
  end
  wire rst_n = rst_b_r;

  localparam PW = 7 + AW + LANES + LANES*LW;
  reg [PW-1:0] pin_a_r, pin_b_r;
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pin_a_r <= {PW{1'b0}};
      pin_b_r <= {PW{1'b0}};
    end else begin
      pin_a_r <= {edge_hold_n, advance_or_load, read_not_write, select_low_a,
                  select_low_b, select_high, burst_order_sel_n, addr,
                  lane_write_strobes_n, wr_data};
      pin_b_r <= pin_a_r;
    end
  end
  // pins are sampled together, so relative timing between them is kept
  wire s_hold_n = pin_b_r[PW-1];
  wire s_adv = pin_b_r[PW-2];
  wire s_rnw = pin_b_r[PW-3];
  wire s_cs1_n = pin_b_r[PW-4];
  wire s_cs2_n = pin_b_r[PW-5];
  wire s_cs_hi = pin_b_r[PW-6];
  wire s_order_n = pin_b_r[PW-7];
  wire [AW-1:0] s_addr = pin_b_r[AW+LANES+LANES*LW-1:LANES+LANES*LW];
  wire [LANES-1:0] s_bw_n = pin_b_r[LANES+LANES*LW-1:LANES*LW];
  wire [LANES*LW-1:0] s_data = pin_b_r[LANES*LW-1:0];

  // ---------------------------------------------------------------
  // burst step
  // ---------------------------------------------------------------
  // interleaved order depends on the start word, so the step comes from a beat count
  function [1:0] burst_lo;
    input [1:0] base;
    input [1:0] beat;
    input lin;
    begin
      if (lin)
        burst_lo = base + beat; // [RULE9]
      else
        burst_lo = base ^ beat; // [RULE9]
    end
  endfunction

  // ---------------------------------------------------------------
  // command stage
  // ---------------------------------------------------------------
  wire buf_in_ready;
  // a full buffer holds the pipe like a held edge, so no word drops
  wire en = s_hold_n == 1'b0 && buf_in_ready; // [RULE1]
  wire sel = !s_cs1_n && !s_cs2_n && s_cs_hi; // [RULE6]

  reg act_r, wr_r, lin_r;
  reg [1:0] base_lo_r;
  reg [1:0] beat_r;
  reg [AW-1:0] cur_addr_r;
  reg [AW-1:0] cmd_addr_nxt;
  reg [1:0] beat_nxt;
  reg cmd_v_nxt, cmd_wr_nxt;
  always @* begin
    cmd_v_nxt = 1'b0;
    cmd_wr_nxt = wr_r;
    cmd_addr_nxt = cur_addr_r;
    beat_nxt = beat_r;
    if (!s_adv) begin
      cmd_v_nxt = sel; // [RULE10]
      cmd_wr_nxt = !s_rnw; // [RULE4]
      cmd_addr_nxt = s_addr; // [RULE7]
      beat_nxt = 2'h0;
    end else if (act_r) begin
      cmd_v_nxt = 1'b1; // [RULE8]
      beat_nxt = beat_r + 2'h1;
      cmd_addr_nxt = {cur_addr_r[AW-1:2], burst_lo(base_lo_r, beat_nxt, lin_r)};
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      act_r <= 1'b0;
      wr_r <= 1'b0;
      lin_r <= 1'b0;
      base_lo_r <= 2'h0;
      beat_r <= 2'h0;
      cur_addr_r <= {AW{1'b0}};
    end else if (en) begin // [RULE2]
      act_r <= cmd_v_nxt;
      wr_r <= cmd_wr_nxt;
      cur_addr_r <= cmd_addr_nxt;
      beat_r <= beat_nxt;
      if (!s_adv) begin
        lin_r <= !s_order_n;
        base_lo_r <= s_addr[1:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // write pipeline: strobes lead data by the lag
  // ---------------------------------------------------------------
  localparam LAG = `PSRAM_DATA_LAG;
  // stage outputs, stage 0 nearest the command
  wire [LAG-1:0] pv;
  wire [LAG*AW-1:0] pa;
  wire [LAG*LANES-1:0] pb;
  genvar g;
  generate
    for (g = 0; g < LAG; g = g + 1) begin : g_pipe
      reg v_r;
      reg [AW-1:0] a_r;
      reg [LANES-1:0] b_r;
      wire v_in;
      wire [AW-1:0] a_in;
      wire [LANES-1:0] b_in;
      if (g == 0) begin : g_head
        assign v_in = cmd_v_nxt && cmd_wr_nxt; // [RULE5]
        assign a_in = cmd_addr_nxt;
        assign b_in = ~s_bw_n; // [RULE3]
      end else begin : g_tail
        assign v_in = pv[g-1];
        assign a_in = pa[(g-1)*AW +: AW];
        assign b_in = pb[(g-1)*LANES +: LANES];
      end
      always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          v_r <= 1'b0;
          a_r <= {AW{1'b0}};
          b_r <= {LANES{1'b0}};
        end else if (en) begin // [RULE2]
          v_r <= v_in;
          a_r <= a_in;
          b_r <= b_in;
        end
      end
      assign pv[g] = v_r;
      assign pa[g*AW +: AW] = a_r;
      assign pb[g*LANES +: LANES] = b_r;
    end
  endgenerate

  // pairs strobes from LAG enabled edges ago with data on this edge
  wire push = en && pv[LAG-1]; // [RULE5]

  // ---------------------------------------------------------------
  // two-entry buffer towards the array
  // ---------------------------------------------------------------
  localparam EW = AW + LANES + LANES*LW;
  reg [EW-1:0] mem_r [0:1];
  reg wp_r, rp_r;
  reg [1:0] cnt_r;
  assign buf_in_ready = cnt_r != 2'h2;
  wire pop = wr_valid && wr_ready;
  wire pop_take = cnt_r != 2'h0 && (!wr_valid || pop);

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wp_r <= 1'b0;
      rp_r <= 1'b0;
      cnt_r <= 2'h0;
      mem_r[0] <= {EW{1'b0}};
      mem_r[1] <= {EW{1'b0}};
      wr_valid <= 1'b0;
      wr_addr <= {AW{1'b0}};
      wr_lanes <= {LANES{1'b0}};
      wr_word <= {LANES*LW{1'b0}};
    end else begin
      if (push) begin
        mem_r[wp_r] <= {pa[(LAG-1)*AW +: AW], pb[(LAG-1)*LANES +: LANES], s_data};
        wp_r <= ~wp_r;
      end
      if (pop_take) begin
        {wr_addr, wr_lanes, wr_word} <= mem_r[rp_r];
        rp_r <= ~rp_r;
        wr_valid <= 1'b1;
      end else if (pop) begin
        wr_valid <= 1'b0;
      end
      cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop_take};
    end
  end

  // ---------------------------------------------------------------
  // read requests and status
  // ---------------------------------------------------------------
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_valid <= 1'b0;
      rd_addr <= {AW{1'b0}};
      pipe_stall <= 1'b0;
    end else begin
      rd_valid <= en && cmd_v_nxt && !cmd_wr_nxt;
      if (en)
        rd_addr <= cmd_addr_nxt;
      pipe_stall <= !en;
    end
  end

endmodule

// ==== rtl/psram_defs.vh ====
// constants for the pipelined burst sram control block
`ifndef PSRAM_DEFS_VH
`define PSRAM_DEFS_VH

// ---------------------------------------------------------------
// geometry
// ---------------------------------------------------------------
`define PSRAM_ADDR_W 18
`define PSRAM_LANES 4
`define PSRAM_LANE_W 9
`define PSRAM_BURST_W 2

// ---------------------------------------------------------------
// pipeline timing: data trails command by this many enabled edges
// ---------------------------------------------------------------
`define PSRAM_DATA_LAG 2

// ---------------------------------------------------------------
// buffer
// ---------------------------------------------------------------
`define PSRAM_BUF_DEPTH 2

`endif

// ==== dv/psram_chk_assertions.sv ====
// checker for the sram control core
`timescale 1ns/1ps
module psram_chk #(parameter AW = 18, parameter LANES = 4, parameter LW = 9) (
  // clock and reset
  input wire clk,
  input wire nrst,
  // pins
  input wire edge_hold_n,
  input wire advance_or_load,
  input wire select_low_a,
  input wire select_low_b,
  input wire select_high,
  // write stream
  input wire wr_ready,
  input wire wr_valid,
  input wire [AW-1:0] wr_addr,
  input wire [LANES-1:0] wr_lanes,
  input wire [LANES*LW-1:0] wr_word,
  // read stream and status
  input wire rd_valid,
  input wire [AW-1:0] rd_addr,
  input wire pipe_stall
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  // run of enabled, deselected loads with the array ready; flushes the pipe
  reg [3:0] quiet_r;
  wire sel = !select_low_a && !select_low_b && select_high;
  wire quiet = !edge_hold_n && !advance_or_load && wr_ready && !sel;
  always @(posedge clk or negedge nrst)
    if (!nrst) quiet_r <= 4'h0;
    else quiet_r <= !quiet ? 4'h0 : (quiet_r == 4'hf ? quiet_r : quiet_r + 4'h1);
  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  a_hold_gives_stall: assert property (edge_hold_n |-> ##[2:4] pipe_stall)
    else $error("held edge without stall");
  a_run_no_stall: assert property ((!edge_hold_n && wr_ready)[*5] |-> !pipe_stall)
    else $error("stall with no hold");
  a_freeze_rd_addr: assert property (pipe_stall |-> $stable(rd_addr))
    else $error("read address moved on held edge");
  a_desel_no_rd: assert property (quiet_r > 4'h6 |-> !rd_valid)
    else $error("read while deselected");
  a_desel_no_wr: assert property (quiet_r > 4'ha |-> !wr_valid)
    else $error("write while deselected");
  a_wr_keeps_valid: assert property (wr_valid && !wr_ready |=> wr_valid)
    else $error("write word dropped");
  a_wr_word_steady: assert property (wr_valid && !wr_ready |=>
      $stable(wr_addr) && $stable(wr_lanes) && $stable(wr_word))
    else $error("write word changed while stalled");
  a_reset_quiet: assert property ($rose(nrst) |-> !wr_valid && !rd_valid ##1 !wr_valid && !rd_valid)
    else $error("output active after reset");
  c_read_burst: cover property (rd_valid ##1 rd_valid);
  c_wr_stalled: cover property (wr_valid && !wr_ready);
  c_held: cover property (pipe_stall);
endmodule
bind psram_core psram_chk #(.AW(AW), .LANES(LANES), .LW(LW)) u_chk (.clk(clk), .nrst(nrst),
  .edge_hold_n(edge_hold_n), .advance_or_load(advance_or_load), .select_low_a(select_low_a),
  .select_low_b(select_low_b), .select_high(select_high), .wr_ready(wr_ready),
  .wr_valid(wr_valid), .wr_addr(wr_addr), .wr_lanes(wr_lanes), .wr_word(wr_word),
  .rd_valid(rd_valid),
  .rd_addr(rd_addr), .pipe_stall(pipe_stall));

// ==== dv/psram_sink.sv ====
// array side model taking paired write words
`timescale 1ns/1ps
module psram_sink (
  // clock
  input wire clk,
  // mode and handshake
  input wire slow,
  output reg wr_ready
);
  // slow mode takes every other cycle so the buffer fills
  initial wr_ready = 1'h1;
  always @(posedge clk) wr_ready <= slow ? ~wr_ready : 1'h1;
endmodule

// ==== dv/pipelined_sram_clock_gate_select_test.sv ====
// self-checking bench for the sram control core
`timescale 1ns/1ps
module pipelined_sram_clock_gate_select_test;
  reg clk = 1'h0, nrst = 1'h0, hold = 1'h0, aol = 1'h0, rnw = 1'h1, sa = 1'h1, sb = 1'h1;
  reg sh = 1'h0, bo_n = 1'h1, slow = 1'h0;
  reg [17:0] addr = 18'h0;
  reg [3:0] lanes_n = 4'hf;
  reg [35:0] wdata = 36'h0;
  wire wv, wr, rv;
  wire [17:0] wa, ra;
  wire [3:0] wl;
  wire [35:0] ww;
  wire ps;
  integer miscompares = 0, n_tests = 0, cycles = 0;
  psram_core i_psram_core (.clk(clk), .nrst(nrst), .edge_hold_n(hold), .advance_or_load(aol),
    .read_not_write(rnw), .select_low_a(sa), .select_low_b(sb), .select_high(sh),
    .burst_order_sel_n(bo_n), .addr(addr), .lane_write_strobes_n(lanes_n), .wr_data(wdata),
    .wr_valid(wv), .wr_addr(wa), .wr_lanes(wl), .wr_word(ww), .wr_ready(wr), .rd_valid(rv),
    .rd_addr(ra), .pipe_stall(ps));
  psram_sink i_psram_sink (.clk(clk), .slow(slow), .wr_ready(wr));
  always #2 clk = ~clk;
  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task close_out;
    begin
      if (miscompares == 0 && n_tests > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
    end
  endtask
  task chk(input [35:0] got, input [35:0] exp);
    begin
      n_tests = n_tests + 1;
      if (got !== exp) begin
        miscompares = miscompares + 1;
        $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task step;
    @(posedge clk) #1;
  endtask
  task cmd(input l, input w, input [17:0] a, input [3:0] bn);
    begin
      aol = l;
      rnw = w;
      addr = a;
      lanes_n = bn;
      sa = 1'h0;
      sb = 1'h0;
      sh = 1'h1;
      step;
    end
  endtask
  task idle;
    begin
      aol = 1'h0;
      sh = 1'h0;
      step;
    end
  endtask
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  // one held or deselected read load; a held edge shows one stall cycle
  task t_none(input h, input a, input b, input hi);
    integer j, s;
    begin
      s = 0;
      hold = h;
      aol = 1'h0;
      rnw = 1'h1;
      sa = a;
      sb = b;
      sh = hi;
      step;
      hold = 1'h0;
      idle;
      for (j = 0; j < 8; j = j + 1) begin
        step;
        chk(rv, 36'h0);
        if (ps === 1'h1)
          s = s + 1;
      end
      chk(s, {35'h0, h});
    end
  endtask
  // advances drive write and junk address; both must be ignored
  task t_burst(input lin);
    integer j, k, n;
    reg [17:0] b;
    begin
      b = 18'h000a5;
      // a low order select gives the linear order
      bo_n = ~lin;
      n = 0;
      fork
        begin
          cmd(1'h0, 1'h1, b, 4'hf);
          for (k = 0; k < 3; k = k + 1) cmd(1'h1, 1'h0, 18'h3ffff, 4'hf);
          idle;
        end
        for (j = 0; j < 12; j = j + 1) begin
          step;
          if (rv === 1'h1) begin
            chk(ra, {b[17:2], lin ? b[1:0] + n[1:0] : b[1:0] ^ n[1:0]});
            n = n + 1;
          end
        end
      join
      chk(n, 36'h4);
    end
  endtask
  // back to back writes, deselected while data still due, slow array
  task t_write;
    integer j, n;
    begin
      slow = 1'h1;
      n = 0;
      fork
        begin
          cmd(1'h0, 1'h0, 18'h00100, 4'ha);
          cmd(1'h0, 1'h0, 18'h00204, 4'h3);
          wdata = 36'h123456789;
          idle;
          wdata = 36'hfedcba987;
          idle;
          wdata = 36'h0;
        end
        for (j = 0; j < 16; j = j + 1) begin
          step;
          if (wv === 1'h1 && wr === 1'h1) begin
            chk(wa, n ? 18'h00204 : 18'h00100);
            chk(wl, n ? 4'hc : 4'h5);
            chk(ww, n ? 36'hfedcba987 : 36'h123456789);
            n = n + 1;
          end
        end
      join
      chk(n, 36'h2);
      slow = 1'h0;
    end
  endtask
  // write burst with a held edge inside; data trails by enabled edges only
  task t_wburst;
    integer j, n;
    begin
      n = 0;
      fork
        begin
          cmd(1'h0, 1'h0, 18'h00300, 4'he);
          cmd(1'h1, 1'h1, 18'h3ffff, 4'h7);
          hold = 1'h1;
          step;
          hold = 1'h0;
          wdata = 36'h0aaaa5555;
          idle;
          wdata = 36'h055550aaa;
          idle;
          wdata = 36'h0;
        end
        for (j = 0; j < 16; j = j + 1) begin
          step;
          if (wv === 1'h1 && wr === 1'h1) begin
            chk(wa, n ? 18'h00301 : 18'h00300);
            chk(wl, n ? 4'h8 : 4'h1);
            chk(ww, n ? 36'h055550aaa : 36'h0aaaa5555);
            n = n + 1;
          end
        end
      join
      chk(n, 36'h2);
    end
  endtask
  always @(posedge clk) begin
    cycles = cycles + 1;
    if (cycles == 3000) begin
      miscompares = miscompares + 1;
      close_out;
    end
  end
  initial begin
    repeat (12) @(posedge clk);
    #1 nrst = 1'h1;
    repeat (3) step;
    t_none(1'h1, 1'h0, 1'h0, 1'h1);
    t_none(1'h0, 1'h1, 1'h0, 1'h1);
    t_none(1'h0, 1'h0, 1'h1, 1'h1);
    t_none(1'h0, 1'h0, 1'h0, 1'h0);
    t_burst(1'h1);
    t_burst(1'h0);
    t_write;
    t_wburst;
    close_out;
  end
endmodule
